//--- hdl/pdsm_core.sv
// Loop divide values, output dividers and the first-loop spread
// modulator of a four-loop clock generator.
// Assumes all inputs are synchronous to clk_sys (the PFD clock).
// Functional notes
// (RQ1) Each loop passes a 7-bit reference and 12-bit feedback value.
// (RQ2) First loop feedback is 2*fb+frac+1, or 2*fb when frac is zero.
// (RQ3) Direct output has no divider; each bank has its own divider.
// (RQ4) All-ones code: off or /1; else /2 or /((code+2)*2).
// (RQ5) Disabled divider holds its pin high, low or released.
// (RQ6) Software disables a divider only for a bank never used.
// (RQ7) Spread runs while step period code is nonzero.
// (RQ8) One waveform step every code+2 cycles; codes 5 to 14 only.
// (RQ9) Samples per quadrant are twice the code; codes 1 to 6 only.
// (RQ10) Four quadrants are mirror images of one stored quadrant.
// (RQ11) Six-bit spread offset shifts the waveform; zero is centred.
// (RQ12) Twelve 4-bit delta samples are held; first N are used.
// (RQ13) Waveform starts at the offset and adds each next delta.
// (RQ14) Software keeps the delta sum within 63 minus the offset.
// (RQ15) Dither randomizes the modulator input word's lowest bit.
// (RQ16) Amplitude double doubles the accumulated delta value.
// (RQ17) Software sets amplitude double for amplitudes between 1 and 2.
// (RQ18) Software never spreads with zero offset and all-zero deltas.
// (RQ19) Software programs nonzero frac when first-loop spread is on.
// (RQ20) Fourth loop spread follows its enable bit.
// (RQ21) A modulation cycle lasts four times samples times step period.
// (RQ22) Modulator output is added to the fractional feedback each cycle.
module pdsm_core import pdsm_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N_LOOPS-1:0][REF_W-1:0] ref_div,
  input wire logic [N_LOOPS-1:0][FB_W-1:0] fb_count,
  input wire logic [FRAC_W-1:0] frac_add,
  output logic [N_LOOPS-1:0][REF_W-1:0] loop_ref_div,
  output logic [N_LOOPS-1:0][M_W-1:0] loop_fb_total,
  input wire logic direct_clk_in,
  output logic direct_output,
  input wire logic [N_BANKS-1:0] bank_clk_in,
  input wire logic [N_BANKS-1:0][ODIV_W-1:0] odiv_code,
  input wire logic [N_BANKS-1:0] path_mode_bit,
  input wire logic [N_BANKS-1:0][1:0] off_state_select,
  output logic [N_BANKS-1:0] bank_out,
  output logic [N_BANKS-1:0] bank_oe_n,
  input wire logic [3:0] step_period_code,
  input wire logic [2:0] quadrant_samples_code,
  input wire logic [OFS_W-1:0] spread_offset,
  input wire logic dither_enable,
  input wire logic amplitude_double,
  input wire logic sample_wr_en,
  input wire logic [IDX_W-1:0] sample_wr_idx,
  input wire logic [SAMP_W-1:0] delta_samples,
  output logic spread_active,
  output logic [FBM_W-1:0] fb_spread_word,
  input wire logic fourth_loop_spread_enable,
  output logic fourth_loop_spread_active
);
  // ----------------------------------------------------------
  // Loop divide values
  // ----------------------------------------------------------
  function automatic logic [M_W-1:0] fb_total(
    input logic [FB_W-1:0] fb, input logic [FRAC_W-1:0] fr,
    input logic first);
    logic [M_W-1:0] dbl;
    dbl = {1'b0, fb, 1'b0};
    if (!first) return M_W'(fb); // [RQ1]
    if (fr == '0) return dbl; // [RQ2]
    return dbl + M_W'(fr) + M_W'(1); // [RQ2]
  endfunction

  for (genvar l = 0; l < N_LOOPS; l++) begin : g_loop
    // Registered so downstream sees a settled value
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        loop_ref_div[l] <= '0;
        loop_fb_total[l] <= '0;
      end else begin
        loop_ref_div[l] <= ref_div[l]; // [RQ1]
        loop_fb_total[l] <= fb_total(fb_count[l], frac_add, l == 0);
      end
    end
  end

  // Direct path: a retiming flop only, no divider
  always_ff @(posedge clk_sys) begin
    if (rst) direct_output <= 1'b0;
    else direct_output <= direct_clk_in; // [RQ3]
  end

  // ----------------------------------------------------------
  // Output dividers, one per bank
  // ----------------------------------------------------------
  for (genvar b = 0; b < N_BANKS; b++) begin : g_bank
    logic in_prev_q;
    logic tog_q;
    logic [DCNT_W-1:0] cnt_q;
    logic all_ones, disabled, bypass, rise;
    logic [DCNT_W-1:0] half;
    assign all_ones = odiv_code[b] == ODIV_ALL_ONES;
    assign disabled = all_ones && !path_mode_bit[b]; // [RQ4]
    assign bypass = all_ones && path_mode_bit[b]; // [RQ4]
    assign rise = bank_clk_in[b] && !in_prev_q;
    // Toggle every half period of input rising edges; /2 toggles each rising edge
    assign half = path_mode_bit[b] ?
      DCNT_W'(odiv_code[b]) + ODIV_ADD : DCNT_W'(1); // [RQ4]

    always_ff @(posedge clk_sys) begin
      if (rst) in_prev_q <= 1'b0;
      else in_prev_q <= bank_clk_in[b];
    end

    // Counter parked while off or bypassed so a restart is clean
    always_ff @(posedge clk_sys) begin
      if (rst || disabled || bypass) begin
        cnt_q <= '0;
        tog_q <= 1'b0;
      end else if (rise) begin
        if (cnt_q >= half - DCNT_W'(1)) begin
          cnt_q <= '0;
          tog_q <= ~tog_q; // [RQ4]
        end else begin
          cnt_q <= cnt_q + DCNT_W'(1);
        end
      end
    end

    // Pin drive; a disabled bank stays powered and holds its pin high, low or released
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        bank_out[b] <= 1'b0;
        bank_oe_n[b] <= 1'b1;
      end else if (disabled) begin
        bank_out[b] <= off_state_select[b] == OFF_HIGH; // [RQ5]
        bank_oe_n[b] <= !(off_state_select[b] == OFF_LOW ||
                          off_state_select[b] == OFF_HIGH); // [RQ5]
      end else begin
        bank_out[b] <= bypass ? bank_clk_in[b] : tog_q;
        bank_oe_n[b] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Spread modulator, first loop
  // ----------------------------------------------------------
  pdsm_mem_if mem_bus ();
  pdsm_sample_mem u_mem (
    .clk_sys (clk_sys),
    .rst (rst),
    .bus (mem_bus.mem)
  );

  logic active, step;
  logic [4:0] per_cnt_q;
  logic [IDX_W-1:0] idx_q, last_idx;
  logic [ACC_W-1:0] acc_q, samp;
  logic [LFSR_W-1:0] lfsr_q;
  logic [ACC_W:0] scaled;
  logic signed [MOD_W-1:0] mod_d, mod_q;
  pdsm_quad_t quad_q;

  assign active = step_period_code != 4'h0; // [RQ7]
  assign step = active &&
    per_cnt_q == 5'(step_period_code) + TSSC_ADD_M1; // [RQ8]
  assign last_idx = IDX_W'({quadrant_samples_code, 1'b0}) -
    IDX_W'(1); // [RQ9]
  assign samp = ACC_W'(mem_bus.rd_data);
  // Read address moves only on a step or when spread stops, and steps are at least
  // three cycles apart (seven for codes 5 to 14), so the registered read is always settled
  assign mem_bus.rd_idx = idx_q;
  assign mem_bus.wr_en = sample_wr_en;
  assign mem_bus.wr_idx = sample_wr_idx;
  assign mem_bus.wr_data = delta_samples;

  // Step period counter
  always_ff @(posedge clk_sys) begin
    if (rst || !active || step) per_cnt_q <= '0;
    else per_cnt_q <= per_cnt_q + 5'h01; // [RQ8]
  end

  // Walk one stored quadrant up, back down, and repeat mirrored
  always_ff @(posedge clk_sys) begin
    if (rst || !active) begin
      idx_q <= '0;
      acc_q <= '0;
      quad_q <= PDSM_RISE_A;
    end else if (step) begin
      case (quad_q)
        PDSM_RISE_A, PDSM_RISE_B: begin
          acc_q <= acc_q + samp; // [RQ13]
          if (idx_q == last_idx) begin
            quad_q <= quad_q == PDSM_RISE_A ? PDSM_FALL_A : PDSM_FALL_B;
          end else begin
            idx_q <= idx_q + IDX_W'(1);
          end
        end
        default: begin
          acc_q <= acc_q - samp; // [RQ10]
          if (idx_q == '0) begin
            quad_q <= quad_q == PDSM_FALL_A ? PDSM_RISE_B : PDSM_RISE_A;
          end else begin
            idx_q <= idx_q - IDX_W'(1); // [RQ21]
          end
        end
      endcase
    end
  end

  // Free-running dither source
  always_ff @(posedge clk_sys) begin
    if (rst) lfsr_q <= LFSR_SEED;
    else lfsr_q <= {lfsr_q[6:0],
                    lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end

  // Second half of the cycle is the first half sign-flipped
  always_comb begin
    scaled = amplitude_double ? {acc_q, 1'b0} : {1'b0, acc_q}; // [RQ16]
    scaled[0] = scaled[0] ^ (dither_enable & lfsr_q[0]); // [RQ15]
    if (quad_q == PDSM_RISE_B || quad_q == PDSM_FALL_B) begin
      mod_d = MOD_W'(spread_offset) - MOD_W'(scaled); // [RQ10]
    end else begin
      mod_d = MOD_W'(spread_offset) + MOD_W'(scaled); // [RQ11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !active) mod_q <= '0;
    else mod_q <= mod_d;
  end

  // Feedback in 1/64 units; wraps if software breaks the delta limit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fb_spread_word <= '0;
      spread_active <= 1'b0;
    end else begin
      spread_active <= active; // [RQ7]
      fb_spread_word <= FBM_W'({loop_fb_total[0], 6'h00}) +
        {{(FBM_W-MOD_W){mod_q[MOD_W-1]}}, mod_q}; // [RQ22]
    end
  end

  // Fourth loop: the spread arithmetic lives elsewhere
  always_ff @(posedge clk_sys) begin
    if (rst) fourth_loop_spread_active <= 1'b0;
    else fourth_loop_spread_active <= fourth_loop_spread_enable; // [RQ20]
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rise_end;
    step && quad_q == PDSM_RISE_A && idx_q == last_idx;
  endsequence
  sequence s_cycle_end;
    step && quad_q == PDSM_FALL_B && idx_q == '0;
  endsequence

  a_first_loop_fb: assert property ( // [RQ2]
    ##1 loop_fb_total[0] == ($past(frac_add) == 4'h0 ?
      M_W'({$past(fb_count[0]), 1'b0}) :
      M_W'({$past(fb_count[0]), 1'b0}) + M_W'($past(frac_add)) + 14'h0001))
    else $error("first loop feedback total wrong");
  a_other_loop_fb: assert property ( // [RQ1]
    ##1 loop_fb_total[3] == M_W'($past(fb_count[3])) &&
        loop_ref_div[2] == $past(ref_div[2]))
    else $error("loop divide value not passed through");
  a_div_bypass: assert property ( // [RQ4]
    odiv_code[3] == ODIV_ALL_ONES && path_mode_bit[3]
    |=> bank_out[3] == $past(bank_clk_in[3]) && !bank_oe_n[3])
    else $error("divide by one does not follow input");
  a_off_hold: assert property ( // [RQ5]
    odiv_code[1] == ODIV_ALL_ONES && !path_mode_bit[1] &&
    off_state_select[1] == OFF_HIGH |=> bank_out[1] && !bank_oe_n[1])
    else $error("disabled bank not held high");
  a_spread_idle: assert property ( // [RQ7]
    step_period_code == 4'h0 |=> mod_q == '0 && !step && !spread_active)
    else $error("modulator running with zero step period");
  a_step_gap: assert property ( // [RQ8]
    step && step_period_code >= 4'h5 |=> !step [*6])
    else $error("waveform steps too close together");
  a_quad_turn: assert property ( // [RQ9]
    s_rise_end |=> quad_q == PDSM_FALL_A && idx_q == $past(idx_q))
    else $error("quadrant length wrong");
  a_mirror_close: assert property ( // [RQ10]
    s_cycle_end |=> quad_q == PDSM_RISE_A && acc_q == '0)
    else $error("waveform does not close after four quadrants");
  a_start_offset: assert property ( // [RQ13]
    $rose(active) && !dither_enable |=> ##1
      mod_q == MOD_W'($past(spread_offset)))
    else $error("waveform does not start at the offset");
  a_fb_sum: assert property ( // [RQ22]
    ##1 fb_spread_word == FBM_W'({$past(loop_fb_total[0]), 6'h00}) +
      {{(FBM_W-MOD_W){$past(mod_q[MOD_W-1])}}, $past(mod_q)})
    else $error("modulation not added to feedback");
  a_fourth_loop_follow: assert property ( // [RQ20]
    $changed(fourth_loop_spread_enable) |=> fourth_loop_spread_active != $past(
      fourth_loop_spread_active))
    else $error("fourth loop spread does not follow enable");
endmodule // pdsm_core

//--- hdl/pdsm_pkg.sv
// Constants shared by the divider and spread modulator block.
// Assumes one clock domain and no register bus.
package pdsm_pkg;
  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int N_LOOPS = 4;
  localparam int N_BANKS = 6;
  localparam int REF_W = 7;
  localparam int FB_W = 12;
  localparam int FRAC_W = 4;
  localparam int M_W = 14;
  localparam int ODIV_W = 7;
  localparam int DCNT_W = 8;
  localparam int N_SAMPLES = 12;
  localparam int SAMP_W = 4;
  localparam int IDX_W = 4;
  localparam int ACC_W = 8;
  localparam int OFS_W = 6;
  localparam int MOD_W = 11;
  localparam int FRAC_SHIFT = 6;
  localparam int FBM_W = 21;
  localparam int LFSR_W = 8;
  // ----------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------
  localparam logic [ODIV_W-1:0] ODIV_ALL_ONES = 7'h7F;
  localparam logic [DCNT_W-1:0] ODIV_ADD = 8'h02;
  localparam logic [1:0] OFF_LOW = 2'h0;
  localparam logic [1:0] OFF_HIGH = 2'h1;
  localparam logic [4:0] TSSC_ADD_M1 = 5'h01;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 8'hA5;
  typedef enum {PDSM_RISE_A, PDSM_FALL_A, PDSM_RISE_B, PDSM_FALL_B}
    pdsm_quad_t;
endpackage

//--- hdl/pdsm_mem_if.sv
// Carrier between the modulator and its delta-sample store.
// Assumes both ends sit on clk_sys.
interface pdsm_mem_if;
  import pdsm_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [SAMP_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [SAMP_W-1:0] rd_data;
  modport core (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport mem (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

//--- hdl/pdsm_sample_mem.sv
// Twelve-entry store of 4-bit delta samples with a registered read.
// Assumes writes to indices above eleven are dropped.
module pdsm_sample_mem import pdsm_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  pdsm_mem_if.mem bus
);
  logic [SAMP_W-1:0] mem_q [N_SAMPLES];
  logic [SAMP_W-1:0] rd_q;

  // ----------------------------------------------------------
  // Storage, one entry per generate step
  // ----------------------------------------------------------
  for (genvar e = 0; e < N_SAMPLES; e++) begin : g_ent
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        mem_q[e] <= '0;
      end else if (bus.wr_en && bus.wr_idx == IDX_W'(e)) begin
        mem_q[e] <= bus.wr_data; // [RQ12]
      end
    end
  end

  // Registered read; out of range reads as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q <= '0;
    end else if (bus.rd_idx < IDX_W'(N_SAMPLES)) begin
      rd_q <= mem_q[bus.rd_idx];
    end else begin
      rd_q <= '0;
    end
  end
  assign bus.rd_data = rd_q;
endmodule // pdsm_sample_mem

//--- bench/pdsm_tb.sv
// Self-checking bench for the divider and spread modulator core.
// Assumes the core alone, driven straight at its ports on clk_sys.
module testbench import pdsm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst, direct_clk_in, direct_output, dither_enable;
  logic amplitude_double, sample_wr_en, spread_active;
  logic fourth_loop_spread_enable, fourth_loop_spread_active;
  logic [N_LOOPS-1:0][REF_W-1:0] ref_div, loop_ref_div;
  logic [N_LOOPS-1:0][FB_W-1:0] fb_count;
  logic [N_LOOPS-1:0][M_W-1:0] loop_fb_total;
  logic [FRAC_W-1:0] frac_add;
  logic [N_BANKS-1:0] bank_clk_in, path_mode_bit, bank_out, bank_oe_n;
  logic [N_BANKS-1:0][ODIV_W-1:0] odiv_code;
  logic [N_BANKS-1:0][1:0] off_state_select;
  logic [3:0] step_period_code;
  logic [2:0] quadrant_samples_code;
  logic [OFS_W-1:0] spread_offset;
  logic [IDX_W-1:0] sample_wr_idx;
  logic [SAMP_W-1:0] delta_samples;
  logic [FBM_W-1:0] fb_spread_word;
  logic [1:0] bcnt = 2'h0;
  int err_count, comparisons;

  pdsm_core dut (.clk_sys(clk_sys), .rst(rst), .ref_div(ref_div),
    .fb_count(fb_count), .frac_add(frac_add), .loop_ref_div(loop_ref_div),
    .loop_fb_total(loop_fb_total), .direct_clk_in(direct_clk_in),
    .direct_output(direct_output), .bank_clk_in(bank_clk_in),
    .odiv_code(odiv_code), .path_mode_bit(path_mode_bit),
    .off_state_select(off_state_select), .bank_out(bank_out),
    .bank_oe_n(bank_oe_n), .step_period_code(step_period_code),
    .quadrant_samples_code(quadrant_samples_code),
    .spread_offset(spread_offset), .dither_enable(dither_enable),
    .amplitude_double(amplitude_double), .sample_wr_en(sample_wr_en),
    .sample_wr_idx(sample_wr_idx), .delta_samples(delta_samples),
    .spread_active(spread_active), .fb_spread_word(fb_spread_word),
    .fourth_loop_spread_enable(fourth_loop_spread_enable),
    .fourth_loop_spread_active(fourth_loop_spread_active));

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;
  // Bank source at a quarter of clk_sys, safely under the half-rate limit
  always @(posedge clk_sys) begin
    bcnt <= bcnt + 2'h1;
    bank_clk_in <= {N_BANKS{bcnt[1]}};
  end
  // ----------------------------------------------------------
  // Compare, verdict and model helpers
  // ----------------------------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [FBM_W-1:0] e,
                          input logic [FBM_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Total feedback value a loop should report for the present inputs
  function automatic logic [M_W-1:0] fb_tot(input int l);
    if (l != 0) return M_W'(fb_count[l]);
    if (frac_add == 4'h0) return M_W'({fb_count[0], 1'b0});
    return M_W'(2 * fb_count[0] + frac_add + 1);
  endfunction
  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  task automatic t_loops();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      ref_div <= 28'($urandom);
      fb_count <= 48'({$urandom, $urandom});
      frac_add <= (i == 0) ? 4'h0 : 4'($urandom);
      @(posedge clk_sys);
      @(negedge clk_sys);
      for (int l = 0; l < N_LOOPS; l++) begin
        chk_word("loop_fb_total", FBM_W'(fb_tot(l)),
                 FBM_W'(loop_fb_total[l]));
        chk_word("loop_ref_div", FBM_W'(ref_div[l]),
                 FBM_W'(loop_ref_div[l]));
      end
    end
    $display("loops test done");
  endtask
  task automatic t_pins();
    logic d, e;
    for (int i = 0; i < 8; i++) begin
      d = 1'($urandom);
      e = 1'($urandom);
      @(posedge clk_sys);
      direct_clk_in <= d;
      fourth_loop_spread_enable <= e;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk_bit("direct_output", d, direct_output);
      chk_bit("fourth_loop_spread_active", e, fourth_loop_spread_active);
    end
    $display("pins test done");
  endtask
  // Cycles between two rises of one bank output
  task automatic period(input int b, input int exp);
    int n;
    logic p;
    for (int r = 0; r < 2; r++) begin
      n = 0;
      do begin
        p = bank_out[b];
        @(negedge clk_sys);
        n++;
      end while (!(p === 1'b0 && bank_out[b] === 1'b1) && n < 300);
    end
    chk_word("bank period", FBM_W'(exp), FBM_W'(n));
  endtask
  // Banks 0-2 are never used, so only they are disabled
  task automatic t_banks(input logic [1:0] sel);
    logic [ODIV_W-1:0] q;
    q = ODIV_W'($urandom_range(3, 0));
    @(posedge clk_sys);
    odiv_code <= {q, q, {4{ODIV_ALL_ONES}}};
    path_mode_bit <= 6'h28;
    off_state_select <= {2'h0, 2'h0, 2'h0, sel, OFF_HIGH, OFF_LOW};
    repeat (20) @(negedge clk_sys);
    repeat (12) begin
      @(negedge clk_sys);
      chk_word("off pins", FBM_W'(6'h02), FBM_W'(bank_out[1:0]));
      chk_word("off enables", FBM_W'(6'h04), FBM_W'(bank_oe_n[2:0]));
    end
    period(3, 4);
    period(4, 8);
    period(5, 8 * (q + 2));
    $display("banks test done");
  endtask
  task automatic t_spread(input logic [3:0] code, input logic [2:0] nsc,
                          input logic x2, input logic [OFS_W-1:0] ofs);
    int nn, acc, sc, n, q;
    int s[16];
    logic [FBM_W-1:0] base, e, prev;
    nn = 2 * nsc;
    acc = 0;
    @(posedge clk_sys);
    frac_add <= 4'($urandom_range(15, 1)); // Nonzero while spreading
    spread_offset <= ofs;
    quadrant_samples_code <= nsc;
    amplitude_double <= x2;
    // Even nonzero deltas, sum kept under 63 less offset
    for (int i = 0; i < 16; i++) begin
      s[i] = (i < nn) ? 2 * $urandom_range(2, 1) : 15;
      @(posedge clk_sys);
      sample_wr_en <= 1'b1;
      sample_wr_idx <= IDX_W'(i);
      delta_samples <= SAMP_W'(s[i]);
    end
    @(posedge clk_sys);
    sample_wr_en <= 1'b0;
    step_period_code <= code;
    base = FBM_W'({fb_tot(0), 6'h00});
    // Active one edge after the code, offset on the word one edge later
    repeat (3) @(negedge clk_sys);
    chk_bit("spread_active", 1'b1, spread_active);
    chk_word("spread start", base + ofs, fb_spread_word);
    prev = fb_spread_word;
    for (int k = 0; k < 4 * nn; k++) begin
      q = k / nn;
      acc = (q % 2 == 0) ? acc + s[k % nn] : acc - s[nn - 1 - k % nn];
      sc = x2 ? 2 * acc : acc;
      e = base + FBM_W'((q < 2) ? ofs + sc : ofs - sc);
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (fb_spread_word === prev && n < 40);
      chk_word("spread step", e,
               fb_spread_word);
      if (k > 0) chk_word("step gap", FBM_W'(code + 2),
                          FBM_W'(n));
      prev = fb_spread_word;
    end
    @(posedge clk_sys);
    step_period_code <= 4'h0;
    repeat (3) @(negedge clk_sys);
    chk_bit("spread_active", 1'b0, spread_active);
    chk_word("spread off", base, fb_spread_word);
    $display("spread test done");
  endtask
  task automatic t_dither();
    int hits;
    logic [FBM_W-1:0] p;
    hits = 0;
    @(posedge clk_sys);
    dither_enable <= 1'b1;
    step_period_code <= 4'h5;
    @(negedge clk_sys);
    p = fb_spread_word;
    repeat (200) begin
      @(negedge clk_sys);
      if (fb_spread_word[FBM_W-1:1] === p[FBM_W-1:1] &&
          fb_spread_word[0] !== p[0]) hits++;
      p = fb_spread_word;
    end
    chk_bit("dither lsb", 1'b1, hits > 0);
    @(posedge clk_sys);
    step_period_code <= 4'h0;
    dither_enable <= 1'b0;
    $display("dither test done");
  endtask
  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    {rst, direct_clk_in} = '0;
    rst = 1'b1;
    {ref_div, fb_count, frac_add, odiv_code, off_state_select} = '0;
    {path_mode_bit, step_period_code, quadrant_samples_code} = '0;
    {spread_offset, dither_enable, amplitude_double, sample_wr_en} = '0;
    {sample_wr_idx, delta_samples, fourth_loop_spread_enable} = '0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(67));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk_word("reset enables", FBM_W'(6'h3F), FBM_W'(bank_oe_n));
    chk_word("reset spread word", '0, fb_spread_word);
    t_loops();
    t_pins();
    t_banks(2'h2);
    t_banks(2'h3);
    t_spread(4'h5, 3'h1, 1'b0, OFS_W'($urandom_range(15, 1)));
    t_spread(4'hE, 3'h6, 1'b1, 6'h00); // Amplitude taken in 1..2
    t_spread(4'h9, 3'h3, 1'b0, 6'h07);
    t_dither();
    conclude();
  end
  initial begin
    #(25 * 40000);
    err_count++;
    conclude();
  end
endmodule // testbench
